// ===== rtl/pf_pkg.sv
// Package: constants, field layouts and carrier types of the power-to-pulse converter
package pf_pkg;

    // Clock and sampling
    localparam int CLK_HZ = 100_000_000;
    localparam int LPF_CORNER_HZ = 8;
    localparam int LPF_SHIFT = 6;
    localparam int PI_X10000 = 31416;
    // Sample rate at which a first-order filter of gain 2^-LPF_SHIFT has its corner at 8 Hz
    localparam int LPF_FS_HZ = (2 * PI_X10000 * LPF_CORNER_HZ * (1 << LPF_SHIFT)) / 10000;
    localparam int SAMPLE_DIV_DFLT = CLK_HZ / LPF_FS_HZ;
    localparam int DIV_W = 16;

    // Pulse widths, as times and as clock cycles
    localparam int LOW_PULSE_US = 100_000;
    localparam int CAL_PULSE_US = 500;
    localparam int LOW_PULSE_CYC = LOW_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int CAL_PULSE_CYC = CAL_PULSE_US * (CLK_HZ / 1_000_000);
    localparam int PULSE_CNT_W = 32;

    // Data path widths
    localparam int PWR_W = 24;
    localparam int LPF_FRAC = 8;
    localparam int LPF_W = PWR_W + LPF_FRAC;
    localparam int SUM_W = 27;
    localparam int WEIGHT_W = 10;
    localparam int INC_W = 38;
    localparam int ACC_W = 48;

    // Transfer function: freq = 6.181 * P * f_base / Vref^2
    localparam longint XFER_GAIN_MILLI = 6181;
    localparam longint VREF_SQ_HUNDREDTHS = 576;
    localparam longint FS_PRODUCT_INV = 4;
    localparam longint POWER_FULL_SCALE = 64'h0000_0000_0080_0000;
    localparam longint LOW_THRESH_L = longint'(LPF_FS_HZ) * POWER_FULL_SCALE * 100
        * FS_PRODUCT_INV * VREF_SQ_HUNDREDTHS * 10 / XFER_GAIN_MILLI;
    localparam logic [ACC_W-1:0] LOW_THRESH = ACC_W'(LOW_THRESH_L);

    // Base frequencies in hundredths of a hertz, by select code {cal, hi, lo}
    localparam logic [WEIGHT_W-1:0] BASE_000 = 10'h0E0;
    localparam logic [WEIGHT_W-1:0] BASE_001 = 10'h070;
    localparam logic [WEIGHT_W-1:0] BASE_010 = 10'h1FD;
    localparam logic [WEIGHT_W-1:0] BASE_011 = 10'h038;
    localparam logic [WEIGHT_W-1:0] BASE_100 = 10'h1C1;
    localparam logic [WEIGHT_W-1:0] BASE_101 = 10'h1C1;
    localparam logic [WEIGHT_W-1:0] BASE_110 = 10'h070;
    localparam logic [WEIGHT_W-1:0] BASE_111 = 10'h038;

    // Calibration to low-rate pulse ratio, by select code {cal, hi, lo}
    localparam logic [7:0] RATIO_000 = 8'h10;
    localparam logic [7:0] RATIO_001 = 8'h20;
    localparam logic [7:0] RATIO_010 = 8'hA0;
    localparam logic [7:0] RATIO_011 = 8'h20;
    localparam logic [7:0] RATIO_100 = 8'h08;
    localparam logic [7:0] RATIO_101 = 8'h10;
    localparam logic [7:0] RATIO_110 = 8'h10;
    localparam logic [7:0] RATIO_111 = 8'h10;

    // Register offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_NOLOAD = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_CAL_COUNT = 12'h00C;
    localparam logic [11:0] OFF_LOW_COUNT = 12'h010;
    localparam logic [11:0] OFF_POWER = 12'h014;

    // Reset values and field positions
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] NOLOAD_RESET = 32'h0000_0200;
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_REV_BIT = 0;
    localparam int ST_SUPPLY_BIT = 1;
    localparam int ST_MODE_BIT = 2;
    localparam int ST_SEL_POS = 3;
    localparam int NOLOAD_W = 23;

    // Carrier types
    typedef struct packed {
        logic signed [PWR_W-1:0] a;
        logic signed [PWR_W-1:0] b;
        logic signed [PWR_W-1:0] c;
    } pf_power_t;

    typedef struct packed {
        logic cal;
        logic hi;
        logic lo;
    } pf_sel_t;

endpackage

// ===== rtl/pf_d2f.sv
// Energy accumulator with threshold pulse generation and pulse stretcher
`timescale 1ns/100ps
module pf_d2f #(
    parameter int PULSE_CYC = 1000
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic tick,
    input wire logic signed [pf_pkg::INC_W-1:0] inc,
    input wire logic [pf_pkg::ACC_W-1:0] thresh,
    output logic fire,
    output logic level
);
    import pf_pkg::*;

    logic signed [ACC_W-1:0] acc_reg;
    logic signed [ACC_W-1:0] acc_next;
    logic fire_reg;
    logic [PULSE_CNT_W-1:0] cnt_reg;

    wire logic signed [ACC_W-1:0] acc_sum = acc_reg + ACC_W'(inc);
    wire logic signed [ACC_W-1:0] th_s = $signed(thresh);
    wire logic cross_pos = acc_sum >= th_s;
    wire logic cross_neg = acc_sum <= -th_s;

    // Crossing in either direction emits one pulse and pulls the total back by one quantum
    always_comb begin
        acc_next = acc_sum;
        if (cross_pos) begin
            acc_next = acc_sum - th_s;
        end else if (cross_neg) begin
            acc_next = acc_sum + th_s;
        end
    end

    // Integration: the residue carries over, so ripple averages out over many samples
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            acc_reg <= '0;
            fire_reg <= 1'b0;
        end else if (clr) begin
            acc_reg <= '0;
            fire_reg <= 1'b0;
        end else begin
            fire_reg <= tick & (cross_pos | cross_neg);
            if (tick) begin
                acc_reg <= acc_next;
            end
        end
    end

    // Fixed-width stretch; a crossing during a pulse restarts it rather than queueing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (clr) begin
            cnt_reg <= '0;
        end else if (fire_reg) begin
            cnt_reg <= PULSE_CNT_W'(PULSE_CYC);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign fire = fire_reg;
    assign level = cnt_reg != '0;

endmodule

// ===== rtl/pf_core.sv
// Power-to-pulse converter: filters, phase summing, pulse outputs and APB registers
`timescale 1ns/100ps
module pf_core #(
    parameter int SAMPLE_DIV = pf_pkg::SAMPLE_DIV_DFLT,
    parameter int LOW_PULSE_CYC = pf_pkg::LOW_PULSE_CYC,
    parameter int CAL_PULSE_CYC = pf_pkg::CAL_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [31:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire pf_pkg::pf_power_t phase_power,
    input wire logic sum_mode_select_n,
    input wire logic cal_rate_select,
    input wire logic rate_select_hi,
    input wire logic rate_select_lo,
    input wire logic supply_ok,
    output logic low_rate_pulse_a,
    output logic low_rate_pulse_b,
    output logic calibration_pulse,
    output logic reverse_power_flag
);
    import pf_pkg::*;

    // Magnitude of a filtered phase value; -2^23 still fits unsigned 24 bits
    function automatic logic [PWR_W-1:0] pf_mag(input logic signed [PWR_W-1:0] v);
        pf_mag = v[PWR_W-1] ? PWR_W'(-v) : PWR_W'(v);
    endfunction

    // Base frequency weight for a select code
    function automatic logic [WEIGHT_W-1:0] pf_weight(input pf_sel_t s);
        case (s)
            3'b000: pf_weight = BASE_000;
            3'b001: pf_weight = BASE_001;
            3'b010: pf_weight = BASE_010;
            3'b011: pf_weight = BASE_011;
            3'b100: pf_weight = BASE_100;
            3'b101: pf_weight = BASE_101;
            3'b110: pf_weight = BASE_110;
            default: pf_weight = BASE_111;
        endcase
    endfunction

    // Calibration threshold: the low-rate quantum split by the code's ratio
    function automatic logic [ACC_W-1:0] pf_cal_thresh(input pf_sel_t s);
        logic [7:0] r;
        case (s)
            3'b000: r = RATIO_000;
            3'b001: r = RATIO_001;
            3'b010: r = RATIO_010;
            3'b011: r = RATIO_011;
            3'b100: r = RATIO_100;
            3'b101: r = RATIO_101;
            3'b110: r = RATIO_110;
            default: r = RATIO_111;
        endcase
        pf_cal_thresh = LOW_THRESH / ACC_W'(r);
    endfunction

    // Pin synchronisers: all four straps and the supply monitor come from outside
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    wire logic [4:0] pins_raw = {supply_ok, sum_mode_select_n, cal_rate_select,
                                 rate_select_hi, rate_select_lo};

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= pins_raw;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    wire logic supply_good = pin_sync_reg[4];
    wire logic arith_mode = pin_sync_reg[3];
    pf_sel_t sel;
    assign sel = pf_sel_t'(pin_sync_reg[2:0]);

    // Software-visible registers
    logic [31:0] ctrl_reg;
    logic [NOLOAD_W-1:0] noload_reg;
    logic [31:0] cal_count_reg;
    logic [31:0] low_count_reg;

    // Data path is held cleared while the supply is bad or software disables it
    wire logic dp_clr = ~supply_good | ~ctrl_reg[CTRL_EN_BIT];

    // Sample tick from the master clock; every output rate scales with clk
    logic [DIV_W-1:0] div_cnt_reg;
    wire logic tick = div_cnt_reg == DIV_W'(SAMPLE_DIV - 1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_reg <= '0;
        end else if (dp_clr || tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    // Per-phase low-pass: y += (x - y) / 2^LPF_SHIFT at the sample tick
    logic signed [PWR_W-1:0] raw_s [3];
    logic signed [PWR_W-1:0] filt_s [3];
    logic signed [PWR_W-1:0] gated_s [3];
    logic [PWR_W-1:0] mag_s [3];
    logic [2:0] below;

    assign raw_s[0] = phase_power.a;
    assign raw_s[1] = phase_power.b;
    assign raw_s[2] = phase_power.c;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_phase
            logic signed [LPF_W-1:0] lpf_reg;
            wire logic signed [LPF_W:0] lpf_err =
                (LPF_W + 1)'($signed({raw_s[gi], 8'h00})) - (LPF_W + 1)'(lpf_reg);
            wire logic signed [LPF_W:0] lpf_step = lpf_err >>> LPF_SHIFT;

            // Line harmonics are only attenuated here, the pulse converter averages the rest
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    lpf_reg <= '0;
                end else if (dp_clr) begin
                    lpf_reg <= '0;
                end else if (tick) begin
                    lpf_reg <= lpf_reg + LPF_W'(lpf_step);
                end
            end

            assign filt_s[gi] = lpf_reg[LPF_W-1:LPF_FRAC];
            assign mag_s[gi] = pf_mag(filt_s[gi]);
            // Creep suppression: a phase under the no-load level contributes nothing
            assign below[gi] = mag_s[gi] < PWR_W'(noload_reg);
            assign gated_s[gi] = below[gi] ? '0 : filt_s[gi];
        end
    endgenerate

    wire logic all_below = &below;

    // Phase combination
    wire logic signed [SUM_W-1:0] arith_sum =
        SUM_W'(gated_s[0]) + SUM_W'(gated_s[1]) + SUM_W'(gated_s[2]);
    wire logic signed [SUM_W-1:0] abs_sum =
        SUM_W'({1'b0, pf_mag(gated_s[0])}) + SUM_W'({1'b0, pf_mag(gated_s[1])})
        + SUM_W'({1'b0, pf_mag(gated_s[2])});
    wire logic signed [SUM_W-1:0] combined = arith_mode ? arith_sum : abs_sum;
    wire logic arith_neg = arith_sum < 0;

    // Scale by base frequency so the rate follows 6.181*P*f_base/Vref^2
    wire logic [WEIGHT_W-1:0] weight = pf_weight(sel);
    wire logic signed [INC_W-1:0] inc =
        INC_W'(combined) * INC_W'($signed({1'b0, weight}));
    wire logic [ACC_W-1:0] cal_thresh = pf_cal_thresh(sel);

    // Both converters see the same increment, so their counts stay in ratio
    logic cal_fire;
    logic cal_level;
    logic low_fire;
    logic low_level;

    pf_d2f #(
        .PULSE_CYC(CAL_PULSE_CYC)
    ) u_cal (
        .clk(clk),
        .rst(rst),
        .clr(dp_clr),
        .tick(tick),
        .inc(inc),
        .thresh(cal_thresh),
        .fire(cal_fire),
        .level(cal_level)
    );

    // Long quantum averages twice-line ripple; ac full scale lands at half dc rate
    pf_d2f #(
        .PULSE_CYC(LOW_PULSE_CYC)
    ) u_low (
        .clk(clk),
        .rst(rst),
        .clr(dp_clr),
        .tick(tick),
        .inc(inc),
        .thresh(LOW_THRESH),
        .fire(low_fire),
        .level(low_level)
    );

    // Output stage: low-rate pulses alternate between the two outputs
    logic low_phase_reg;
    logic low_a_reg;
    logic low_b_reg;
    logic cal_out_reg;
    logic rev_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            low_phase_reg <= 1'b0;
            low_a_reg <= 1'b0;
            low_b_reg <= 1'b0;
            cal_out_reg <= 1'b0;
        end else if (dp_clr) begin
            low_phase_reg <= 1'b0;
            low_a_reg <= 1'b0;
            low_b_reg <= 1'b0;
            cal_out_reg <= 1'b0;
        end else begin
            if (low_fire) begin
                low_phase_reg <= ~low_phase_reg;
            end
            low_a_reg <= low_level & low_phase_reg;
            low_b_reg <= low_level & ~low_phase_reg;
            cal_out_reg <= cal_level;
        end
    end

    // Reverse flag: sampled only with a calibration pulse, dropped when every phase idles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rev_reg <= 1'b0;
        end else if (dp_clr) begin
            rev_reg <= 1'b0;
        end else if (all_below) begin
            rev_reg <= 1'b0;
        end else if (cal_fire) begin
            rev_reg <= arith_neg;
        end
    end

    assign low_rate_pulse_a = low_a_reg;
    assign low_rate_pulse_b = low_b_reg;
    assign calibration_pulse = cal_out_reg;
    assign reverse_power_flag = rev_reg;

    // APB decode; one wait state so prdata and pready come from flip-flops
    wire logic [11:0] addr = paddr[11:0];
    wire logic hi_zero = paddr[31:12] == '0;
    wire logic hit_ctrl = hi_zero && addr == OFF_CTRL;
    wire logic hit_noload = hi_zero && addr == OFF_NOLOAD;
    wire logic hit_status = hi_zero && addr == OFF_STATUS;
    wire logic hit_cal = hi_zero && addr == OFF_CAL_COUNT;
    wire logic hit_low = hi_zero && addr == OFF_LOW_COUNT;
    wire logic hit_power = hi_zero && addr == OFF_POWER;
    wire logic hit_any = hit_ctrl | hit_noload | hit_status | hit_cal | hit_low | hit_power;

    logic pready_reg;
    logic pslverr_reg;
    logic [31:0] prdata_reg;
    logic [31:0] rdata_dec;
    wire logic access_start = psel & penable & ~pready_reg;
    wire logic commit = psel & penable & pready_reg & pwrite & hit_any;

    // Status word
    logic [31:0] status_word;
    assign status_word = {26'h0, sel, arith_mode, supply_good, rev_reg};

    always_comb begin
        rdata_dec = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata_dec = ctrl_reg;
        end else if (hit_noload) begin
            rdata_dec = 32'(noload_reg);
        end else if (hit_status) begin
            rdata_dec = status_word;
        end else if (hit_cal) begin
            rdata_dec = cal_count_reg;
        end else if (hit_low) begin
            rdata_dec = low_count_reg;
        end else if (hit_power) begin
            rdata_dec = 32'(combined);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access_start;
            pslverr_reg <= access_start & ~hit_any;
            prdata_reg <= (access_start & ~pwrite) ? rdata_dec : 32'h0000_0000;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // Writable controls; only bit 0 of control is implemented
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            noload_reg <= NOLOAD_W'(NOLOAD_RESET);
        end else if (commit) begin
            if (hit_ctrl) begin
                ctrl_reg <= {31'h0, pwdata[CTRL_EN_BIT]};
            end else if (hit_noload) begin
                noload_reg <= pwdata[NOLOAD_W-1:0];
            end
        end
    end

    // Pulse counters: a write to a counter clears it, a pulse in the same cycle still counts
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_count_reg <= 32'h0000_0000;
            low_count_reg <= 32'h0000_0000;
        end else begin
            if (commit && hit_cal) begin
                cal_count_reg <= {31'h0, cal_fire};
            end else if (cal_fire) begin
                cal_count_reg <= cal_count_reg + 1'b1;
            end
            if (commit && hit_low) begin
                low_count_reg <= {31'h0, low_fire};
            end else if (low_fire) begin
                low_count_reg <= low_count_reg + 1'b1;
            end
        end
    end

endmodule

// ===== sim/pf_core_sva.sv
// Concurrent checks on the APB handshake and the pulse pins of the converter
`timescale 1ns/100ps
module pf_core_sva #(
    parameter int LOW_PULSE_CYC = 20,
    parameter int CAL_PULSE_CYC = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    input wire logic supply_ok,
    input wire logic low_rate_pulse_a,
    input wire logic low_rate_pulse_b,
    input wire logic calibration_pulse,
    input wire logic reverse_power_flag
);
    int cal_run;
    int low_run;

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // Length of the current high run; a merged restart would show as a longer run on the calibration pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cal_run <= 0;
            low_run <= 0;
        end else begin
            cal_run <= calibration_pulse ? cal_run + 1 : 0;
            low_run <= low_rate_pulse_a ? low_run + 1 : 0;
        end
    end

    apb_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("prdata nonzero outside answer");
    rev_with_cal_a: assert property ($rose(reverse_power_flag) |=> calibration_pulse)
        else $error("reverse flag rose without calibration pulse");
    quiet_supply_a: assert property (!supply_ok [*6] |->
        !(low_rate_pulse_a || low_rate_pulse_b || calibration_pulse || reverse_power_flag))
        else $error("output active while supply invalid");
    cal_width_a: assert property ($fell(calibration_pulse) |-> cal_run == CAL_PULSE_CYC)
        else $error("calibration pulse width wrong");
    low_width_a: assert property ($fell(low_rate_pulse_a) |-> low_run == LOW_PULSE_CYC)
        else $error("low-rate pulse width wrong");
    low_excl_a: assert property (!(low_rate_pulse_a && low_rate_pulse_b))
        else $error("both low-rate outputs high");
endmodule

bind pf_core pf_core_sva #(.LOW_PULSE_CYC(LOW_PULSE_CYC), .CAL_PULSE_CYC(CAL_PULSE_CYC)) u_sva (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .supply_ok(supply_ok),
    .low_rate_pulse_a(low_rate_pulse_a), .low_rate_pulse_b(low_rate_pulse_b),
    .calibration_pulse(calibration_pulse), .reverse_power_flag(reverse_power_flag));

// ===== sim/pf_pulse_counter.sv
// Host-side pulse counter model for the calibration and low-rate outputs
`timescale 1ns/100ps
module pf_pulse_counter (
    input wire logic clk,
    input wire logic rst,
    input wire logic low_a,
    input wire logic low_b,
    input wire logic cal,
    output int cal_count,
    output int low_count,
    output int order_err
);
    logic a_q;
    logic b_q;
    logic c_q;
    logic want_b;

    // Counts rising edges; pulses are asynchronous to the host, so it integrates over many
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            c_q <= 1'b0;
            want_b <= 1'b0;
            cal_count <= 0;
            low_count <= 0;
            order_err <= 0;
        end else begin
            a_q <= low_a;
            b_q <= low_b;
            c_q <= cal;
            if (cal && !c_q) cal_count <= cal_count + 1;
            if ((low_a && !a_q) || (low_b && !b_q)) low_count <= low_count + 1;
            if (low_a && !a_q) want_b <= 1'b1;
            if (low_b && !b_q) want_b <= 1'b0;
            // Stepper drive expects strict a, b, a, b order
            if ((low_a && !a_q && want_b) || (low_b && !b_q && !want_b))
                order_err <= order_err + 1;
        end
    end
endmodule

// ===== sim/test_pf_core.sv
// Self-checking bench for the power-to-pulse converter
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected %0t: got %0h expected %0h", $time, got, exp); end end
module test_pf_core;
    import pf_pkg::*;
    localparam logic signed [PWR_W-1:0] FULL = 24'h7FFFFF;
    localparam int SDIV = 4;
    // Expected low-rate period in clocks at full power on all phases, code 010
    localparam longint LOW_PER = LOW_THRESH_L * SDIV / (3 * longint'(FULL) * BASE_010);
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [31:0] paddr = 32'h0000_0000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pf_power_t phase_power = '0;
    logic sum_mode_select_n = 1'b1;
    logic cal_rate_select = 1'b0;
    logic rate_select_hi = 1'b0;
    logic rate_select_lo = 1'b0;
    logic supply_ok = 1'b1;
    logic low_a;
    logic low_b;
    logic cal;
    logic rev;
    int n_errors = 0;
    int checks = 0;
    int cal_n;
    int low_n;
    int order_err;
    int c1;
    logic [31:0] q;
    logic err;
    longint p_ar;
    longint p_ab;
    longint t0;

    pf_core #(.SAMPLE_DIV(SDIV), .LOW_PULSE_CYC(20), .CAL_PULSE_CYC(4)) DUT (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .phase_power(phase_power), .sum_mode_select_n(sum_mode_select_n),
        .cal_rate_select(cal_rate_select), .rate_select_hi(rate_select_hi),
        .rate_select_lo(rate_select_lo), .supply_ok(supply_ok), .low_rate_pulse_a(low_a),
        .low_rate_pulse_b(low_b), .calibration_pulse(cal), .reverse_power_flag(rev));

    pf_pulse_counter host (.clk(clk), .rst(rst), .low_a(low_a), .low_b(low_b), .cal(cal),
        .cal_count(cal_n), .low_count(low_n), .order_err(order_err));

    // Free-running 100 MHz clock
    always #5 clk = ~clk;

    // One APB transfer, entered at a rising edge; held until pready is sampled high
    task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        q = prdata;
        err = pslverr;
        `CHK(n < 50, 1'b1)
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task rdc(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK(q, exp)
    endtask

    // Waits are bounded so a dead output cannot hang the run
    task wait_flag(input logic v);
        int n;
        n = 0;
        while (rev !== v && n < 8000) begin
            @(posedge clk);
            n++;
        end
        `CHK(rev, v)
    endtask

    task wait_low(input int k);
        int n;
        n = 0;
        while (low_n < k && n < 20000) begin
            @(posedge clk);
            n++;
        end
        `CHK(low_n >= k, 1'b1)
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run of about 15k cycles
    initial begin
        #500_000;
        n_errors++;
        $display("unexpected %0t: watchdog expired", $time);
        stop_test;
    end

    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Reset values, field masks and an unmapped address
        rdc(OFF_CTRL, CTRL_RESET);
        rdc(OFF_NOLOAD, NOLOAD_RESET);
        xfer(1'b1, OFF_NOLOAD, 32'hFFFF_FFFF);
        rdc(OFF_NOLOAD, 32'h007F_FFFF);
        xfer(1'b1, OFF_NOLOAD, NOLOAD_RESET);
        xfer(1'b0, 32'h0000_0040, 32'h0000_0000);
        `CHK({err, q}, 33'h1_0000_0000)
        $display("test registers done");
        // Every select code is seen by the core
        for (int i = 0; i < 8; i++) begin
            {cal_rate_select, rate_select_hi, rate_select_lo} <= 3'(i);
            repeat (4) @(posedge clk);
            xfer(1'b0, OFF_STATUS, 32'h0000_0000);
            `CHK(q[5:3], 3'(i))
        end
        {cal_rate_select, rate_select_hi, rate_select_lo} <= 3'h2;
        $display("test select done");
        // Pulse ratio between the two accumulators at the fastest code
        phase_power <= {FULL, FULL, FULL};
        wait_low(1);
        c1 = cal_n;
        t0 = $time;
        wait_low(2);
        `CHK((cal_n - c1) inside {[158:162]}, 1'b1)
        `CHK(($time - t0) / 10 * 100 inside {[LOW_PER*99:LOW_PER*101]}, 1'b1)
        `CHK(rev, 1'b0)
        `CHK(order_err, 0)
        $display("test ratio done");
        // Reverse flag across both summing modes and its release paths
        phase_power <= {FULL, -FULL, -FULL};
        wait_flag(1'b1);
        repeat (2500) @(posedge clk);
        xfer(1'b0, OFF_POWER, 32'h0000_0000);
        p_ar = longint'($signed(q));
        `CHK(p_ar < 0, 1'b1)
        sum_mode_select_n <= 1'b0;
        repeat (8) @(posedge clk);
        xfer(1'b0, OFF_POWER, 32'h0000_0000);
        p_ab = longint'($signed(q));
        `CHK(p_ab * 100 >= -p_ar * 297 && p_ab * 100 <= -p_ar * 303, 1'b1)
        repeat (200) @(posedge clk);
        `CHK(rev, 1'b1)
        phase_power <= {FULL, FULL, FULL};
        wait_flag(1'b0);
        phase_power <= {FULL, -FULL, -FULL};
        wait_flag(1'b1);
        phase_power <= '0;
        wait_flag(1'b0);
        sum_mode_select_n <= 1'b1;
        $display("test reverse done");
        // Counters match the host tally once no pulse is in flight; a pulse cut by
        // the supply drop would be counted inside but never seen by the host
        repeat (100) @(posedge clk);
        rdc(OFF_CAL_COUNT, 32'(cal_n));
        rdc(OFF_LOW_COUNT, 32'(low_n));
        // Supply loss keeps the outputs quiet even under full power
        supply_ok <= 1'b0;
        repeat (10) @(posedge clk);
        phase_power <= {FULL, FULL, FULL};
        xfer(1'b0, OFF_STATUS, 32'h0000_0000);
        `CHK(q[1], 1'b0)
        c1 = cal_n;
        repeat (300) @(posedge clk);
        `CHK(cal_n, c1)
        xfer(1'b1, OFF_CAL_COUNT, 32'h0000_0000);
        rdc(OFF_CAL_COUNT, 32'h0000_0000);
        supply_ok <= 1'b1;
        repeat (2000) @(posedge clk);
        `CHK(cal_n > c1, 1'b1)
        $display("test supply done");
        stop_test;
    end
endmodule
